/* calc_pkg.sv */
// Constants for the user-variable / X-register calculation datapath.
// Assumes byte-wide framed commands and a single 25 MHz clock domain.
package calc_pkg;

	// ==========================================================
	// Frame layout
	localparam logic [3:0] FRAME_LAST   = 4'h8;
	localparam logic [3:0] IDX_ADDR     = 4'h0;
	localparam logic [3:0] IDX_INSTR    = 4'h1;
	localparam logic [3:0] IDX_TYPE     = 4'h2;
	localparam logic [3:0] IDX_BANK     = 4'h3;
	localparam logic [3:0] IDX_VAL_LO   = 4'h4;
	localparam logic [3:0] IDX_VAL_HI   = 4'h7;

	// ==========================================================
	// Addresses and instruction codes
	localparam logic [7:0] MODULE_ADDR  = 8'h01;
	localparam logic [7:0] HOST_ADDR    = 8'h02;
	localparam logic [7:0] INSTR_VAR_OP_XREG = 8'h2b;
	localparam logic [7:0] INSTR_XREG_OP_VAR = 8'h2c;

	// ==========================================================
	// Operation type codes
	localparam logic [7:0] OP_ADD  = 8'h00;
	localparam logic [7:0] OP_SUB  = 8'h01;
	localparam logic [7:0] OP_MUL  = 8'h02;
	localparam logic [7:0] OP_DIV  = 8'h03;
	localparam logic [7:0] OP_MOD  = 8'h04;
	localparam logic [7:0] OP_AND  = 8'h05;
	localparam logic [7:0] OP_OR   = 8'h06;
	localparam logic [7:0] OP_XOR  = 8'h07;
	localparam logic [7:0] OP_NOT  = 8'h08;
	localparam logic [7:0] OP_LOAD = 8'h09;
	localparam logic [7:0] OP_SWAP = 8'h0a;
	localparam logic [7:0] OP_COMP = 8'h0b;

	// ==========================================================
	// Reply status codes
	localparam logic [7:0] STATUS_OK        = 8'h64;
	localparam logic [7:0] STATUS_BAD_CMD   = 8'h02;
	localparam logic [7:0] STATUS_BAD_TYPE  = 8'h03;
	localparam logic [7:0] STATUS_DIV_ZERO  = 8'h04;

	// ==========================================================
	// Storage
	localparam int         VAR_COUNT    = 256;
	localparam logic [31:0] XREG_RESET  = 32'h0000_0000;

endpackage

/* var_mem_if.sv */
// Port bundle between the calculation controller and user-variable storage.
// Assumes both ends share one clock.
`timescale 1ns/1ps
`default_nettype none

interface var_mem_if;
	logic        we;
	logic [7:0]  addr;
	logic [31:0] wdata;
	logic [31:0] rdata;

	modport ctrl (output we, output addr, output wdata, input rdata);
	modport mem  (input we, input addr, input wdata, output rdata);
endinterface

`default_nettype wire

/* user_var_mem.sv */
// Storage for the 256 user variables, 32 bits each, with registered read.
// Assumes the address is held stable one cycle before read data are used.
`timescale 1ns/1ps
`default_nettype none

module user_var_mem (
	input  wire logic i_clock,
	var_mem_if.mem    bus
);
	logic [31:0] store [calc_pkg::VAR_COUNT];
	logic [31:0] rdata_r;

	// Read returns the old word during a write to the same index.
	always_ff @(posedge i_clock) begin
		if (bus.we) begin
			store[bus.addr] <= bus.wdata;
		end
		rdata_r <= store[bus.addr];
	end

	assign bus.rdata = rdata_r;
endmodule

`default_nettype wire

/* user_var_x_register_alu.sv */
// Command frame decoder and datapath combining a user variable and the X register.
// Assumes byte streams with valid/ready handshake, synchronous to i_clock.
//
// Behaviour
// - code 43 updates variable with X.
// - code 44 updates X with variable.
// - code 43 types 0-4 are arithmetic.
// - code 43 types 5-8 are bitwise.
// - code 43 types 9-11 load, swap, compare.
// - code 44 types 0-4 are arithmetic.
// - code 44 types 5-8 are bitwise.
// - code 44 types 9-11 load, swap, compare.
// - bank byte indexes variable; value ignored.
// - reply nine bytes, status (100 on success, else 2, 3 or 4) and result.
`timescale 1ns/1ps
`default_nettype none

module user_var_x_register_alu (
	input  wire logic       i_clock,
	input  wire logic       i_rst,
	input  wire logic [7:0] i_rx_data,
	input  wire logic       i_rx_valid,
	output logic            o_rx_ready,
	output logic [7:0]      o_tx_data,
	output logic            o_tx_valid,
	input  wire logic       i_tx_ready,
	output logic [31:0]     o_xreg,
	output logic            o_flag_eq,
	output logic            o_flag_lt
);
	// ==========================================================
	// State
	typedef enum logic [1:0] {S_RX, S_FETCH, S_EXEC, S_TX} phase_t;

	typedef struct packed {
		phase_t      phase;
		logic [3:0]  cnt;
		logic [7:0]  sum;
		logic        addr_ok;
		logic [7:0]  instr;
		logic [7:0]  typ;
		logic [7:0]  status;
		logic [31:0] xreg;
		logic [31:0] result;
		logic        eq;
		logic        lt;
		logic        rx_ready;
		logic        tx_valid;
		logic [7:0]  tx_data;
		logic        mem_we;
		logic [7:0]  mem_addr;
		logic [31:0] mem_wdata;
	} state_t;

	state_t s_r;
	state_t s_nxt;

	var_mem_if vbus ();

	user_var_mem u_mem (
		.i_clock (i_clock),
		.bus     (vbus.mem)
	);

	assign vbus.we    = s_r.mem_we;
	assign vbus.addr  = s_r.mem_addr;
	assign vbus.wdata = s_r.mem_wdata;

	// ==========================================================
	// Operation unit
	// Dest is the operand that receives the result, src the other one.
	function automatic logic [31:0] calc(input logic [7:0] typ,
	                                     input logic [31:0] dest,
	                                     input logic [31:0] src);
		logic [31:0] r;
		r = dest;
		case (typ)
			calc_pkg::OP_ADD:  r = dest + src;
			calc_pkg::OP_SUB:  r = dest - src;
			calc_pkg::OP_MUL:  r = 32'($signed(dest) * $signed(src));
			calc_pkg::OP_DIV:  r = 32'($signed(dest) / $signed(src));
			calc_pkg::OP_MOD:  r = 32'($signed(dest) % $signed(src));
			calc_pkg::OP_AND:  r = dest & src;
			calc_pkg::OP_OR:   r = dest | src;
			calc_pkg::OP_XOR:  r = dest ^ src;
			calc_pkg::OP_NOT:  r = ~src;
			calc_pkg::OP_LOAD: r = src;
			calc_pkg::OP_SWAP: r = src;
			default:           r = dest;
		endcase
		return r;
	endfunction

	// Reply byte for a given position; position 8 returns the running sum held in s.sum.
	function automatic logic [7:0] reply_byte(input logic [3:0] idx, input state_t s);
		logic [7:0] b;
		b = 8'h00;
		case (idx)
			4'h0: b = calc_pkg::HOST_ADDR;
			4'h1: b = calc_pkg::MODULE_ADDR;
			4'h2: b = s.status;
			4'h3: b = s.instr;
			4'h4: b = s.result[31:24];
			4'h5: b = s.result[23:16];
			4'h6: b = s.result[15:8];
			4'h7: b = s.result[7:0];
			default: b = s.sum;
		endcase
		return b;
	endfunction

	logic [31:0] dest;
	logic [31:0] src;
	logic        var_is_dest;
	logic        div_op;
	logic [7:0]  nbyte;

	always_comb begin
		// code 43 takes the variable as destination.
		// code 44 takes X as destination.
		var_is_dest = (s_r.instr == calc_pkg::INSTR_VAR_OP_XREG);
		dest        = var_is_dest ? vbus.rdata : s_r.xreg;
		src         = var_is_dest ? s_r.xreg : vbus.rdata;
		div_op      = (s_r.typ == calc_pkg::OP_DIV) || (s_r.typ == calc_pkg::OP_MOD);
		nbyte       = 8'h00;

		s_nxt        = s_r;
		s_nxt.mem_we = 1'b0;

		unique case (s_r.phase)
			S_RX: begin
				if (i_rx_valid && s_r.rx_ready) begin
					// running sum of the first eight bytes.
					s_nxt.sum = s_r.sum + i_rx_data;
					s_nxt.cnt = s_r.cnt + 4'h1;
					// fixed byte positions within the frame.
					case (s_r.cnt)
						calc_pkg::IDX_ADDR:  s_nxt.addr_ok = (i_rx_data == calc_pkg::MODULE_ADDR);
						calc_pkg::IDX_INSTR: s_nxt.instr = i_rx_data;
						calc_pkg::IDX_TYPE:  s_nxt.typ = i_rx_data;
						// bank byte is the variable index.
						calc_pkg::IDX_BANK:  s_nxt.mem_addr = i_rx_data;
						default: ;
					endcase
					// the four value bytes are summed but otherwise ignored.
					if (s_r.cnt == calc_pkg::FRAME_LAST) begin
						s_nxt.cnt = 4'h0;
						s_nxt.sum = 8'h00;
						// a frame with a bad sum or foreign address is dropped.
						if (s_r.sum == i_rx_data && s_r.addr_ok) begin
							s_nxt.phase    = S_FETCH;
							s_nxt.rx_ready = 1'b0;
						end
					end
				end
			end
			S_FETCH: begin
				s_nxt.phase = S_EXEC;
			end
			S_EXEC: begin
				s_nxt.status = calc_pkg::STATUS_OK;
				s_nxt.result = 32'h0000_0000;
				if (s_r.instr != calc_pkg::INSTR_VAR_OP_XREG && s_r.instr != calc_pkg::INSTR_XREG_OP_VAR) begin
					s_nxt.status = calc_pkg::STATUS_BAD_CMD;
				end else if (s_r.typ > calc_pkg::OP_COMP) begin
					s_nxt.status = calc_pkg::STATUS_BAD_TYPE;
				end else if (div_op && src == 32'h0000_0000) begin
					// A zero divisor leaves both operands untouched.
					s_nxt.status = calc_pkg::STATUS_DIV_ZERO;
				end else if (s_r.typ == calc_pkg::OP_COMP) begin
					// compare variable against X, nothing stored.
					// compare X against variable, nothing stored.
					s_nxt.eq     = (dest == src);
					s_nxt.lt     = ($signed(dest) < $signed(src));
					s_nxt.result = dest;
				end else begin
					s_nxt.result = calc(s_r.typ, dest, src);
					if (var_is_dest) begin
						// result written back to the variable.
						s_nxt.mem_we    = 1'b1;
						s_nxt.mem_wdata = calc(s_r.typ, dest, src);
						// swap also moves the variable into X.
						if (s_r.typ == calc_pkg::OP_SWAP) begin
							s_nxt.xreg = dest;
						end
					end else begin
						s_nxt.xreg = calc(s_r.typ, dest, src);
						// swap also moves X into the variable.
						if (s_r.typ == calc_pkg::OP_SWAP) begin
							s_nxt.mem_we    = 1'b1;
							s_nxt.mem_wdata = dest;
						end
					end
				end
				// reply starts with the host address.
				s_nxt.phase    = S_TX;
				s_nxt.cnt      = 4'h0;
				s_nxt.tx_valid = 1'b1;
				s_nxt.tx_data  = calc_pkg::HOST_ADDR;
				s_nxt.sum      = calc_pkg::HOST_ADDR;
			end
			S_TX: begin
				if (i_tx_ready) begin
					if (s_r.cnt == calc_pkg::FRAME_LAST) begin
						s_nxt.phase    = S_RX;
						s_nxt.cnt      = 4'h0;
						s_nxt.sum      = 8'h00;
						s_nxt.tx_valid = 1'b0;
						s_nxt.rx_ready = 1'b1;
					end else begin
						// fields in order, value MSB first, then sum.
						// reply checksum accumulates the eight bytes sent.
						s_nxt.cnt     = s_r.cnt + 4'h1;
						nbyte         = reply_byte(s_r.cnt + 4'h1, s_r);
						s_nxt.tx_data = nbyte;
						if (s_r.cnt + 4'h1 != calc_pkg::FRAME_LAST) begin
							s_nxt.sum = s_r.sum + nbyte;
						end
					end
				end
			end
		endcase
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			s_r          <= '0;
			s_r.phase    <= S_RX;
			s_r.xreg     <= calc_pkg::XREG_RESET;
			s_r.rx_ready <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign o_rx_ready = s_r.rx_ready;
	assign o_tx_data  = s_r.tx_data;
	assign o_tx_valid = s_r.tx_valid;
	assign o_xreg     = s_r.xreg;
	assign o_flag_eq  = s_r.eq;
	assign o_flag_lt  = s_r.lt;
endmodule

`default_nettype wire

/* user_var_x_register_alu_asserts.sv */
// Port checker for the calculation block.
// Bound onto the top module; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module alu_port_chk (
	input wire logic        i_clock,
	input wire logic        i_rst,
	input wire logic        o_rx_ready,
	input wire logic [7:0]  o_tx_data,
	input wire logic        o_tx_valid,
	input wire logic        i_tx_ready,
	input wire logic [31:0] o_xreg,
	input wire logic        o_flag_eq,
	input wire logic        o_flag_lt
);
	// Reply bytes taken so far; cleared while no reply is pending.
	logic [3:0] taken_r;
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst)
			taken_r <= 4'h0;
		else if (!o_tx_valid)
			taken_r <= 4'h0;
		else if (i_tx_ready)
			taken_r <= taken_r + 4'h1;
	end
	// ==========================================================
	// Assertions
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_rst);
	reset_idle_a: assert property ($fell(i_rst) |-> o_rx_ready && !o_tx_valid && o_xreg == 32'h0)
		else $error("bad state after reset");
	one_side_a: assert property (!(o_rx_ready && o_tx_valid))
		else $error("ready during reply");
	reply_hold_a: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data))
		else $error("reply byte lost");
	reply_soon_a: assert property ($fell(o_rx_ready) |-> ##[1:3] $rose(o_tx_valid))
		else $error("reply late");
	host_first_a: assert property ($rose(o_tx_valid) |-> o_tx_data == calc_pkg::HOST_ADDR)
		else $error("first reply byte wrong");
	target_next_a: assert property ($rose(o_tx_valid) && i_tx_ready |=> o_tx_data == calc_pkg::MODULE_ADDR)
		else $error("second reply byte wrong");
	nine_bytes_a: assert property ($fell(o_tx_valid) |-> taken_r == 4'h9)
		else $error("reply length wrong");
	ready_back_a: assert property ($fell(o_tx_valid) |-> ##[0:1] o_rx_ready)
		else $error("not ready after reply");
	idle_hold_a: assert property (o_rx_ready |=> $stable({o_xreg, o_flag_eq, o_flag_lt}))
		else $error("state moved while idle");
	cover property ($rose(o_tx_valid));
	cover property (o_tx_valid && !i_tx_ready);
	cover property ($rose(o_flag_eq));
endmodule
bind user_var_x_register_alu alu_port_chk chk (
	.i_clock(i_clock),
	.i_rst(i_rst),
	.o_rx_ready(o_rx_ready),
	.o_tx_data(o_tx_data),
	.o_tx_valid(o_tx_valid),
	.i_tx_ready(i_tx_ready),
	.o_xreg(o_xreg),
	.o_flag_eq(o_flag_eq),
	.o_flag_lt(o_flag_lt)
);
`default_nettype wire

/* host_frame_model.sv */
// Host that sends command frames and takes replies.
// Tasks are entered just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module host_frame_model (
	input  wire logic       i_clock,
	input  wire logic       i_rx_ready,
	input  wire logic [7:0] i_tx_data,
	input  wire logic       i_tx_valid,
	output logic [7:0]      o_data,
	output logic            o_valid,
	output logic            o_take
);
	logic [7:0] reply [9];
	logic       slow = 1'b0;
	initial begin
		o_data = 8'h00;
		o_valid = 1'b0;
		o_take = 1'b0;
	end
	// ==========================================================
	// frame order and sum
	task automatic send(input logic [7:0] ins, typ, bank, input logic [31:0] v, input logic [7:0] adr, err);
		logic [7:0] f [9];
		logic       rdy;
		f = '{adr, ins, typ, bank, v[31:24], v[23:16], v[15:8], v[7:0], err};
		for (int i = 0; i < 8; i++) f[8] += f[i];
		for (int i = 0; i < 9; i++) begin
			o_data = f[i];
			o_valid = 1'b1;
			do begin
				rdy = i_rx_ready;
				@(posedge i_clock);
				#1;
			end while (!rdy);
		end
		o_valid = 1'b0;
		// A released line shows no stale byte.
		o_data = ~f[8];
	endtask
	task automatic recv();
		logic ok;
		int   n;
		n = 0;
		while (n < 9) begin
			o_take = slow ? ~o_take : 1'b1;
			ok = o_take && i_tx_valid;
			reply[n] = i_tx_data;
			@(posedge i_clock);
			#1;
			if (ok)
				n++;
		end
		o_take = 1'b0;
	endtask
endmodule
`default_nettype wire

/* user_var_x_register_alu_tb.sv */
// Self-checking bench for the calculation block.
// Host model drives frames; a bench model predicts replies.
`timescale 1ns/1ps
`default_nettype none
module user_var_x_register_alu_tb;
	logic        clock = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  rx_data, tx_data, idx [4];
	logic        rx_valid, rx_ready, tx_valid, tx_ready, flag_eq, flag_lt;
	logic [31:0] xreg, vars [256], r, x_m = 32'h0, seed = 32'he0bb;
	logic        eq_m = 1'b0, lt_m = 1'b0;
	int          bad_count = 0, total_checks = 0;
	always #20 clock = ~clock;
	user_var_x_register_alu dut (.i_clock(clock), .i_rst(rst), .i_rx_data(rx_data), .i_rx_valid(rx_valid),
		.o_rx_ready(rx_ready), .o_tx_data(tx_data), .o_tx_valid(tx_valid), .i_tx_ready(tx_ready),
		.o_xreg(xreg), .o_flag_eq(flag_eq), .o_flag_lt(flag_lt));
	host_frame_model host (.i_clock(clock), .i_rx_ready(rx_ready), .i_tx_data(tx_data),
		.i_tx_valid(tx_valid), .o_data(rx_data), .o_valid(rx_valid), .o_take(tx_ready));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic check(input logic [31:0] got, want);
		total_checks++;
		if (got !== want) begin
			bad_count++;
			$display("[FAIL] t=%0t got=%h want=%h", $time, got, want);
		end
	endtask
	task automatic give_verdict();
		$display("checks=%0d mismatches=%0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// ==========================================================
	// Reference model and one full command
	task automatic run(input logic [7:0] ins, typ, bank);
		logic [31:0] d, s, q;
		logic [7:0]  st, e [9];
		logic        xd;
		xd = ins == calc_pkg::INSTR_XREG_OP_VAR;
		d = xd ? x_m : vars[bank];
		s = xd ? vars[bank] : x_m;
		q = d;
		st = calc_pkg::STATUS_OK;
		if (!xd && ins != calc_pkg::INSTR_VAR_OP_XREG)
			st = calc_pkg::STATUS_BAD_CMD;
		else if ((typ == 8'h03 || typ == 8'h04) && s == 32'h0)
			st = calc_pkg::STATUS_DIV_ZERO;
		else case (typ)
			8'h00: q = d + s;
			8'h01: q = d - s;
			8'h02: q = $signed(d) * $signed(s);
			8'h03: q = $signed(d) / $signed(s);
			8'h04: q = $signed(d) % $signed(s);
			8'h05: q = d & s;
			8'h06: q = d | s;
			8'h07: q = d ^ s;
			8'h08: q = ~s;
			8'h09: q = s;
			8'h0a: begin
				q = s;
				s = d;
			end
			8'h0b: begin
				eq_m = d == s;
				lt_m = $signed(d) < $signed(s);
			end
			default: st = calc_pkg::STATUS_BAD_TYPE;
		endcase
		if (st != calc_pkg::STATUS_OK)
			q = 32'h0;
		else if (xd) begin
			x_m = q;
			vars[bank] = s;
		end else begin
			vars[bank] = q;
			x_m = s;
		end
		e = '{calc_pkg::HOST_ADDR, calc_pkg::MODULE_ADDR, st, ins, q[31:24], q[23:16], q[15:8], q[7:0], 8'h00};
		for (int i = 0; i < 8; i++) e[8] += e[i];
		host.slow = rnd() > 32'h8000_0000;
		host.send(ins, typ, bank, rnd(), calc_pkg::MODULE_ADDR, 8'h00);
		host.recv();
		for (int i = 0; i < 9; i++) check(32'(host.reply[i]), 32'(e[i]));
		check(xreg, x_m);
		check(32'({flag_eq, flag_lt}), 32'({eq_m, lt_m}));
	endtask
	initial begin
		repeat (5) @(posedge clock);
		#1 rst = 1'b0;
		for (int k = 0; k < 4; k++) idx[k] = 8'(rnd());
		for (int k = 0; k < 4; k++) run(calc_pkg::INSTR_VAR_OP_XREG, calc_pkg::OP_LOAD, idx[k]);
		// X and the four chosen variables are all zero here, so both divisions must refuse and compare must match.
		run(calc_pkg::INSTR_VAR_OP_XREG, calc_pkg::OP_DIV, idx[0]);
		run(calc_pkg::INSTR_XREG_OP_VAR, calc_pkg::OP_MOD, idx[1]);
		run(calc_pkg::INSTR_XREG_OP_VAR, calc_pkg::OP_COMP, idx[2]);
		run(calc_pkg::INSTR_XREG_OP_VAR, calc_pkg::OP_NOT, idx[0]);
		for (int t = 0; t < 12; t++) begin
			run(calc_pkg::INSTR_VAR_OP_XREG, 8'(t), idx[t % 4]);
			run(calc_pkg::INSTR_XREG_OP_VAR, 8'(t), idx[(t + 1) % 4]);
		end
		repeat (40) begin
			r = rnd();
			run(r[0] ? calc_pkg::INSTR_VAR_OP_XREG : calc_pkg::INSTR_XREG_OP_VAR, 8'(r[11:8] % 12), idx[r[5:4]]);
		end
		run(calc_pkg::INSTR_XREG_OP_VAR + 8'h01, calc_pkg::OP_ADD, idx[0]);
		run(calc_pkg::INSTR_VAR_OP_XREG, 8'h0c, idx[1]);
		host.send(calc_pkg::INSTR_VAR_OP_XREG, calc_pkg::OP_ADD, idx[0], rnd(), calc_pkg::MODULE_ADDR, 8'h01);
		// Let one edge pass so the host does not lower and raise its strobe in a single step.
		@(posedge clock);
		#1;
		host.send(calc_pkg::INSTR_VAR_OP_XREG, calc_pkg::OP_ADD, idx[0], rnd(), 8'h05, 8'h00);
		repeat (12) begin
			@(posedge clock);
			#1 check(32'({tx_valid, rx_ready}), 32'h1);
		end
		run(calc_pkg::INSTR_XREG_OP_VAR, calc_pkg::OP_SUB, idx[2]);
		give_verdict();
	end
	initial begin
		repeat (20000) @(posedge clock);
		bad_count++;
		give_verdict();
	end
endmodule
`default_nettype wire
